/* src/sensor_defines.svh */
`ifndef SENSOR_DEFINES_SVH
`define SENSOR_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define ROUTE_CFG_ADDR      8'hAC
`define FILTER_CFG_ADDR     8'hAD
`define EXIT_CFG_ADDR       8'hB0

// ------------------------------------------------------------
// Reset values and writable-bit masks
// ------------------------------------------------------------
`define ROUTE_CFG_RESET     8'h00
`define FILTER_CFG_RESET    8'h08
`define EXIT_CFG_RESET      8'h00
`define ROUTE_CFG_MASK      8'hF0
`define FILTER_CFG_MASK     8'h2F
`define EXIT_CFG_MASK       8'h3F

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define AMBIENT_PIN_FOLLOW_BIT     7
`define AMBIENT_AUX_PIN_ROUTE_BIT  6
`define NEAR_PIN_FOLLOW_BIT        5
`define NEAR_AUX_PIN_ROUTE_BIT     4
`define AMBIENT_ABORT_BIT          5
`define INFRARED_SUBTRACT_OFF_BIT  3
`define NEAR_AVG_DECIMATE_BIT      2
`define NEAR_AVG_DEPTH_BIT         1
`define NEAR_AVG_ENABLE_BIT        0
`define EXIT_IGNORE_EAST_BIT       5
`define EXIT_IGNORE_WEST_BIT       4
`define EXIT_IGNORE_SOUTH_BIT      3
`define EXIT_IGNORE_NORTH_BIT      2
`define EXIT_PERSIST_MSB           1
`define EXIT_PERSIST_LSB           0

`endif

/* src/sensor_pkg.sv */
package sensor_pkg;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  // Four colour results of one ambient cycle
  typedef struct packed {
    logic [15:0] clear;
    logic [15:0] red;
    logic [15:0] green;
    logic [15:0] blue;
  } color_t;

  // One motion dataset, one byte per direction
  typedef struct packed {
    logic [7:0] north;
    logic [7:0] south;
    logic [7:0] west;
    logic [7:0] east;
  } motion_sample_t;

  // Motion capture state
  typedef enum logic {
    CAP_IDLE,
    CAP_ACTIVE
  } capture_state_t;

endpackage

/* src/sensor_int_filter_config.sv */
`include "sensor_defines.svh"

module sensor_int_filter_config #(
  parameter int NEAR_W = 8
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // Register port
  input  wire logic                      reg_wr_en,
  input  wire logic                      reg_rd_en,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  // Ambient colour path
  input  wire logic                      color_valid,
  input  wire sensor_pkg::color_t        color_raw,
  input  wire logic [15:0]               ambient_low_thr,
  input  wire logic [15:0]               ambient_high_thr,
  output sensor_pkg::color_t             color_result,
  output logic                           color_result_valid,
  // Near path
  input  wire logic                      near_sample_valid,
  input  wire logic [NEAR_W-1:0]         near_sample,
  input  wire logic [NEAR_W-1:0]         near_low_thr,
  input  wire logic [NEAR_W-1:0]         near_high_thr,
  output logic      [NEAR_W-1:0]         near_result,
  output logic                           near_result_valid,
  // Motion capture and ambient integration control
  input  wire logic                      motion_enter,
  input  wire logic                      motion_sample_valid,
  input  wire sensor_pkg::motion_sample_t motion_sample,
  input  wire logic [7:0]                motion_exit_threshold,
  input  wire logic                      ambient_integrating,
  output logic                           motion_capture_state,
  output logic                           motion_exit,
  output logic                           ambient_abort,
  output logic                           ambient_restart,
  output logic                           ambient_skip_wait,
  // Interrupt and auxiliary pins, open drain, low when driven
  input  wire logic                      latched_int_req,
  output logic                           int_pin_o,
  output logic                           int_pin_oe,
  output logic                           aux_pin_o,
  output logic                           aux_pin_oe
);
  import sensor_pkg::*;

  if (NEAR_W < 2 || NEAR_W > 16) begin : g_width_check
    $error("NEAR_W must lie between 2 and 16");
  end

  // ------------------------------------------------------------
  // Reset synchroniser
  // ------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  // Release reset two edges after reset_n rises
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [7:0] route_cfg_ff;
  logic [7:0] filter_cfg_ff;
  logic [7:0] exit_cfg_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_route_cfg;
  logic [7:0] nxt_filter_cfg;
  logic [7:0] nxt_exit_cfg;
  logic [7:0] nxt_rdata;

  // Writes store only defined bits; reserved bits read zero
  always_comb
  begin
    nxt_route_cfg  = route_cfg_ff;
    nxt_filter_cfg = filter_cfg_ff;
    nxt_exit_cfg   = exit_cfg_ff;
    nxt_rdata      = rdata_ff;
    if (reg_wr_en)
    begin
      unique case (reg_addr)
        `ROUTE_CFG_ADDR:  nxt_route_cfg  = reg_wdata & `ROUTE_CFG_MASK;
        `FILTER_CFG_ADDR: nxt_filter_cfg = reg_wdata & `FILTER_CFG_MASK;
        `EXIT_CFG_ADDR:   nxt_exit_cfg   = reg_wdata & `EXIT_CFG_MASK;
        default:          nxt_route_cfg  = route_cfg_ff;
      endcase
    end
    if (reg_rd_en)
    begin
      unique case (reg_addr)
        `ROUTE_CFG_ADDR:  nxt_rdata = route_cfg_ff;
        `FILTER_CFG_ADDR: nxt_rdata = filter_cfg_ff;
        `EXIT_CFG_ADDR:   nxt_rdata = exit_cfg_ff;
        default:          nxt_rdata = 8'h00;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      route_cfg_ff  <= `ROUTE_CFG_RESET;
      filter_cfg_ff <= `FILTER_CFG_RESET;
      exit_cfg_ff   <= `EXIT_CFG_RESET;
      rdata_ff      <= 8'h00;
    end
    else
    begin
      route_cfg_ff  <= nxt_route_cfg;
      filter_cfg_ff <= nxt_filter_cfg;
      exit_cfg_ff   <= nxt_exit_cfg;
      rdata_ff      <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ------------------------------------------------------------
  // Ambient colour correction and window state
  // ------------------------------------------------------------
  color_t     color_ff;
  color_t     nxt_color;
  logic       color_valid_ff;
  logic       ambient_out_ff;
  logic       nxt_ambient_out;
  logic [17:0] ir_sum;
  logic [16:0] ir_val;

  // Subtract with floor at zero
  function automatic logic [15:0] sub_floor(input logic [15:0] a, input logic [16:0] b);
    logic [16:0] d;
    d = {1'b0, a} - b;
    sub_floor = ({1'b0, a} < b) ? 16'h0000 : d[15:0];
  endfunction

  // IR estimate is clamped to zero when the sum goes negative
  always_comb
  begin
    ir_sum = {2'b00, color_raw.red} + {2'b00, color_raw.green}
           + {2'b00, color_raw.blue} - {2'b00, color_raw.clear};
    ir_val = ir_sum[17] ? 17'h0_0000 : ir_sum[17:1];
    nxt_color       = color_ff;
    nxt_ambient_out = ambient_out_ff;
    if (color_valid)
    begin
      nxt_color = color_raw;
      if (!filter_cfg_ff[`INFRARED_SUBTRACT_OFF_BIT])
      begin
        nxt_color.clear = sub_floor(color_raw.clear, ir_val);
        nxt_color.red   = sub_floor(color_raw.red, ir_val);
        nxt_color.green = sub_floor(color_raw.green, ir_val);
        nxt_color.blue  = sub_floor(color_raw.blue, ir_val);
      end
      // Live window state, no software clear needed
      nxt_ambient_out = (nxt_color.clear < ambient_low_thr) ||
                        (nxt_color.clear > ambient_high_thr);
    end
  end

  // Colour result storage
  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      color_ff       <= '0;
      color_valid_ff <= 1'b0;
      ambient_out_ff <= 1'b0;
    end
    else
    begin
      color_ff       <= nxt_color;
      color_valid_ff <= color_valid;
      ambient_out_ff <= nxt_ambient_out;
    end
  end

  assign color_result       = color_ff;
  assign color_result_valid = color_valid_ff;

  // ------------------------------------------------------------
  // Near averaging filter
  // ------------------------------------------------------------
  logic [NEAR_W-1:0] hist_ff [4];
  logic [NEAR_W-1:0] nxt_hist [4];
  logic [1:0]        grp_cnt_ff;
  logic [1:0]        nxt_grp_cnt;
  logic [NEAR_W-1:0] result_ff;
  logic [NEAR_W-1:0] nxt_result;
  logic              result_valid_ff;
  logic              nxt_result_valid;
  logic              near_hi_ff;
  logic              nxt_near_hi;
  logic [NEAR_W+1:0] sum2;
  logic [NEAR_W+1:0] sum4;
  logic [NEAR_W+1:0] avg;
  logic              grp_last;
  logic              avg_on;
  logic              depth4;

  // Sample history shifts by one entry per sample
  assign nxt_hist[0] = near_sample_valid ? near_sample : hist_ff[0];
  for (genvar i = 1; i < 4; i++) begin : g_hist
    assign nxt_hist[i] = near_sample_valid ? hist_ff[i-1] : hist_ff[i];
  end

  // Average, decimate and hysteresis on each published result
  always_comb
  begin
    avg_on = filter_cfg_ff[`NEAR_AVG_ENABLE_BIT];
    depth4 = filter_cfg_ff[`NEAR_AVG_DEPTH_BIT];
    sum2 = {2'b00, near_sample} + {2'b00, hist_ff[0]};
    sum4 = sum2 + {2'b00, hist_ff[1]} + {2'b00, hist_ff[2]};
    avg  = depth4 ? (sum4 >> 2) : (sum2 >> 1);
    grp_last = depth4 ? (grp_cnt_ff == 2'd3) : (grp_cnt_ff[0] == 1'b1);
    nxt_grp_cnt      = grp_cnt_ff;
    nxt_result       = result_ff;
    nxt_result_valid = 1'b0;
    nxt_near_hi      = near_hi_ff;
    if (near_sample_valid)
    begin
      nxt_grp_cnt = grp_last ? 2'd0 : grp_cnt_ff + 2'd1;
      // Decimate publishes on the group's last sample only
      if (!avg_on || !filter_cfg_ff[`NEAR_AVG_DECIMATE_BIT] || grp_last)
      begin
        nxt_result       = avg_on ? avg[NEAR_W-1:0] : near_sample;
        nxt_result_valid = 1'b1;
        if (nxt_result > near_high_thr)
          nxt_near_hi = 1'b1;
        else if (nxt_result < near_low_thr)
          nxt_near_hi = 1'b0;
      end
    end
  end

  // Near filter storage
  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      for (int k = 0; k < 4; k++)
        hist_ff[k] <= '0;
      grp_cnt_ff      <= 2'd0;
      result_ff       <= '0;
      result_valid_ff <= 1'b0;
      near_hi_ff      <= 1'b0;
    end
    else
    begin
      for (int k = 0; k < 4; k++)
        hist_ff[k] <= nxt_hist[k];
      grp_cnt_ff      <= nxt_grp_cnt;
      result_ff       <= nxt_result;
      result_valid_ff <= nxt_result_valid;
      near_hi_ff      <= nxt_near_hi;
    end
  end

  assign near_result       = result_ff;
  assign near_result_valid = result_valid_ff;

  // ------------------------------------------------------------
  // Motion capture exit and ambient abort
  // ------------------------------------------------------------
  capture_state_t cap_ff;
  capture_state_t nxt_cap;
  logic [3:0] pers_cnt_ff;
  logic [3:0] nxt_pers_cnt;
  logic       exit_ff;
  logic       nxt_exit;
  logic       abort_ff;
  logic       nxt_abort;
  logic       restart_ff;
  logic       nxt_restart;
  logic [3:0] below;
  logic [3:0] pers_need;
  logic       all_below;

  // Persistence counter and state transitions
  always_comb
  begin
    below = {motion_sample.east  < motion_exit_threshold,
             motion_sample.west  < motion_exit_threshold,
             motion_sample.south < motion_exit_threshold,
             motion_sample.north < motion_exit_threshold};
    all_below = &(below | exit_cfg_ff[`EXIT_IGNORE_EAST_BIT:`EXIT_IGNORE_NORTH_BIT]);
    pers_need = 4'h1 << exit_cfg_ff[`EXIT_PERSIST_MSB:`EXIT_PERSIST_LSB];
    nxt_cap      = cap_ff;
    nxt_pers_cnt = pers_cnt_ff;
    nxt_exit     = 1'b0;
    nxt_abort    = 1'b0;
    nxt_restart  = 1'b0;
    unique case (cap_ff)
      CAP_IDLE:
      begin
        nxt_pers_cnt = 4'h0;
        if (motion_enter)
        begin
          nxt_cap   = CAP_ACTIVE;
          nxt_abort = filter_cfg_ff[`AMBIENT_ABORT_BIT] && ambient_integrating;
        end
      end
      CAP_ACTIVE:
      begin
        if (motion_sample_valid)
        begin
          if (!all_below)
            nxt_pers_cnt = 4'h0;
          else if (pers_cnt_ff + 4'h1 >= pers_need)
          begin
            nxt_pers_cnt = 4'h0;
            nxt_cap      = CAP_IDLE;
            nxt_exit     = 1'b1;
            nxt_restart  = filter_cfg_ff[`AMBIENT_ABORT_BIT];
          end
          else
            nxt_pers_cnt = pers_cnt_ff + 4'h1;
        end
      end
    endcase
  end

  // Motion storage
  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      cap_ff      <= CAP_IDLE;
      pers_cnt_ff <= 4'h0;
      exit_ff     <= 1'b0;
      abort_ff    <= 1'b0;
      restart_ff  <= 1'b0;
    end
    else
    begin
      cap_ff      <= nxt_cap;
      pers_cnt_ff <= nxt_pers_cnt;
      exit_ff     <= nxt_exit;
      abort_ff    <= nxt_abort;
      restart_ff  <= nxt_restart;
    end
  end

  assign motion_capture_state = (cap_ff == CAP_ACTIVE);
  assign motion_exit          = exit_ff;
  assign ambient_abort        = abort_ff;
  assign ambient_restart      = restart_ff;
  assign ambient_skip_wait    = restart_ff;

  // ------------------------------------------------------------
  // Pin routing
  // ------------------------------------------------------------
  logic amb_aux;
  logic near_aux;
  logic amb_int;
  logic near_int;

  // Aux route takes the state off the interrupt pin
  always_comb
  begin
    amb_aux  = route_cfg_ff[`AMBIENT_AUX_PIN_ROUTE_BIT] && ambient_out_ff;
    near_aux = route_cfg_ff[`NEAR_AUX_PIN_ROUTE_BIT] && near_hi_ff;
    amb_int  = route_cfg_ff[`AMBIENT_PIN_FOLLOW_BIT] &&
               !route_cfg_ff[`AMBIENT_AUX_PIN_ROUTE_BIT] && ambient_out_ff;
    near_int = route_cfg_ff[`NEAR_PIN_FOLLOW_BIT] &&
               !route_cfg_ff[`NEAR_AUX_PIN_ROUTE_BIT] && near_hi_ff;
  end

  assign int_pin_o  = 1'b0;
  assign int_pin_oe = latched_int_req | amb_int | near_int;
  assign aux_pin_o  = 1'b0;
  assign aux_pin_oe = amb_aux | near_aux;

endmodule // sensor_int_filter_config

/* bench/sensor_host_model.sv */
module sensor_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  // Open-drain pins
  input  wire logic       int_pin_o,
  input  wire logic       int_pin_oe,
  input  wire logic       aux_pin_o,
  input  wire logic       aux_pin_oe,
  output logic            int_line,
  output logic            aux_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // Board pull-ups hold the lines high when released
  assign int_line = int_pin_oe ? int_pin_o : 1'b1;
  assign aux_line = aux_pin_oe ? aux_pin_o : 1'b1;
  // Bus idle at time zero
  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // Callers keep reserved bits zero outside the reserved-bit scenario
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  // Read data lands one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    d         = reg_rdata;
  endtask
endmodule // sensor_host_model

/* bench/sensor_int_filter_config_monitor.sv */
module sensor_int_filter_config_monitor
  import sensor_pkg::*;
#(
  parameter int NEAR_W = 8
) (
  // Clock and register port
  input wire logic                       clk,
  input wire logic                       reset_n,
  input wire logic                       reg_wr_en,
  input wire logic [7:0]                 reg_addr,
  input wire logic [7:0]                 reg_wdata,
  // Result paths
  input wire logic                       color_valid,
  input wire sensor_pkg::color_t         color_result,
  input wire logic                       color_result_valid,
  input wire logic [15:0]                ambient_low_thr,
  input wire logic [15:0]                ambient_high_thr,
  input wire logic [NEAR_W-1:0]          near_result,
  input wire logic [NEAR_W-1:0]          near_high_thr,
  input wire logic                       near_result_valid,
  // Motion and pins
  input wire logic                       motion_enter,
  input wire logic                       motion_sample_valid,
  input wire sensor_pkg::motion_sample_t motion_sample,
  input wire logic [7:0]                 motion_exit_threshold,
  input wire logic                       ambient_integrating,
  input wire logic                       motion_capture_state,
  input wire logic                       motion_exit,
  input wire logic                       ambient_abort,
  input wire logic                       ambient_restart,
  input wire logic                       ambient_skip_wait,
  input wire logic                       latched_int_req,
  input wire logic                       int_pin_oe,
  input wire logic                       aux_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] route_ff, filt_ff, exit_ff, run_ff, nxt_run, limit;
  logic       below, amb_out;
  // Quiet test, ignored channels count as quiet
  always_comb
  begin
    below = (exit_ff[5] | (motion_sample.east < motion_exit_threshold))
          & (exit_ff[4] | (motion_sample.west < motion_exit_threshold))
          & (exit_ff[3] | (motion_sample.south < motion_exit_threshold))
          & (exit_ff[2] | (motion_sample.north < motion_exit_threshold));
    amb_out = (color_result.clear < ambient_low_thr) || (color_result.clear > ambient_high_thr);
    limit = 8'h01 << exit_ff[1:0];
    nxt_run = run_ff;
    if (motion_exit)
      nxt_run = 8'h00;
    else if (motion_sample_valid && motion_capture_state)
      nxt_run = below ? run_ff + 8'h01 : 8'h00;
  end
  // Register copies and quiet-run counter
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      route_ff <= 8'h00;
      filt_ff  <= 8'h08;
      exit_ff  <= 8'h00;
      run_ff   <= 8'h00;
    end
    else
    begin
      run_ff <= nxt_run;
      if (reg_wr_en && reg_addr == 8'hAC)
        route_ff <= reg_wdata & 8'hF0;
      if (reg_wr_en && reg_addr == 8'hAD)
        filt_ff <= reg_wdata & 8'h2F;
      if (reg_wr_en && reg_addr == 8'hB0)
        exit_ff <= reg_wdata & 8'h3F;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // --------------------
  // Properties
  // --------------------
  property p_amb_out;
    route_ff == 8'h80 && color_result_valid && amb_out |-> int_pin_oe;
  endproperty
  a_amb_out: assert property (p_amb_out) else $error("ambient out, pin idle");
  property p_amb_in;
    route_ff == 8'h80 && !latched_int_req && color_result_valid && !amb_out |-> !int_pin_oe;
  endproperty
  a_amb_in: assert property (p_amb_in) else $error("ambient in, pin driven");
  property p_amb_aux;
    route_ff[6] && color_result_valid && amb_out |-> aux_pin_oe;
  endproperty
  a_amb_aux: assert property (p_amb_aux) else $error("ambient aux idle");
  property p_near_set;
    route_ff[5:4] == 2'b10 && near_result_valid && near_result > near_high_thr |-> int_pin_oe;
  endproperty
  a_near_set: assert property (p_near_set) else $error("near high, pin idle");
  property p_near_hold;
    route_ff == 8'h20 && $past(route_ff) == 8'h20 && !near_result_valid && !latched_int_req
      && !$past(latched_int_req) |-> int_pin_oe == $past(int_pin_oe);
  endproperty
  a_near_hold: assert property (p_near_hold) else $error("near pin moved");
  property p_near_aux;
    route_ff[4] && near_result_valid && near_result > near_high_thr |-> aux_pin_oe;
  endproperty
  a_near_aux: assert property (p_near_aux) else $error("near aux idle");
  property p_abort;
    motion_enter && !motion_capture_state && ambient_integrating && filt_ff[5] |=> ambient_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_restart;
    motion_exit && filt_ff[5] |-> ambient_restart && ambient_skip_wait;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_color;
    color_valid |=> color_result_valid;
  endproperty
  a_color: assert property (p_color) else $error("no colour result");
  property p_exit_count;
    motion_exit |-> run_ff == limit && !motion_capture_state;
  endproperty
  a_exit_count: assert property (p_exit_count) else $error("exit count wrong");
  property p_no_early;
    motion_capture_state |-> run_ff < limit;
  endproperty
  a_no_early: assert property (p_no_early) else $error("exit missed");
  c_exit: cover property (motion_exit);
  c_abort: cover property (ambient_abort);
  c_near: cover property (near_result_valid && int_pin_oe);
endmodule // sensor_int_filter_config_monitor

bind sensor_int_filter_config sensor_int_filter_config_monitor #(.NEAR_W(NEAR_W)) mon (.*);

/* bench/sensor_int_filter_config_tb.sv */
module sensor_int_filter_config_tb
  import sensor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, color_valid, near_sample_valid, motion_enter, motion_sample_valid;
  logic ambient_integrating, color_result_valid, near_result_valid, motion_capture_state;
  logic motion_exit, ambient_abort, ambient_restart, ambient_skip_wait, reg_wr_en, reg_rd_en;
  logic int_pin_o, int_pin_oe, aux_pin_o, aux_pin_oe, int_line, aux_line;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, near_sample, near_low_thr, near_high_thr;
  logic [7:0] near_result, motion_exit_threshold;
  logic [15:0] ambient_low_thr, ambient_high_thr;
  color_t color_raw, color_result;
  motion_sample_t motion_sample;
  int fail_count, comparisons;
  sensor_int_filter_config #(.NEAR_W(8)) uut (.*, .latched_int_req(1'b0));
  sensor_host_model host (.*);
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // --------------------
  // Shared tasks
  // --------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic col(input logic [63:0] v);
    @(negedge clk);
    color_raw = v;
    color_valid = 1'b1;
    @(negedge clk);
    color_valid = 1'b0;
    color_raw = ~v;
  endtask
  task automatic nr(input logic [7:0] v, output logic p);
    @(negedge clk);
    near_sample = v;
    near_sample_valid = 1'b1;
    @(negedge clk);
    near_sample_valid = 1'b0;
    near_sample = ~v;
    p = near_result_valid;
  endtask
  task automatic enter;
    @(negedge clk);
    motion_enter = 1'b1;
    @(negedge clk);
    motion_enter = 1'b0;
  endtask
  task automatic ms(input logic [31:0] v, output logic ex);
    @(negedge clk);
    motion_sample = v;
    motion_sample_valid = 1'b1;
    @(negedge clk);
    motion_sample_valid = 1'b0;
    motion_sample = ~v;
    ex = motion_exit;
  endtask
  // --------------------
  // Scenarios
  // --------------------
  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] adr [3];
    logic [7:0] rst [3];
    logic [7:0] msk [3];
    adr = '{8'hAC, 8'hAD, 8'hB0};
    rst = '{8'h00, 8'h08, 8'h00};
    msk = '{8'hF0, 8'h2F, 8'h3F};
    for (int i = 0; i < 3; i++)
    begin
      host.rd(adr[i], d);
      check(d, rst[i]);
      host.wr(adr[i], 8'hFF);
      host.rd(adr[i], d);
      check(d, msk[i]);
    end
    host.rd(8'h55, d);
    check(d, 8'h00);
  endtask
  task automatic t_color;
    host.wr(8'hAC, 8'h80);
    host.wr(8'hAD, 8'h00);
    col({16'h0064, 16'h0050, 16'h003C, 16'h0028});
    check(color_result, {16'h003C, 16'h0028, 16'h0014, 16'h0000});
    check(int_line, 1'b1);
    host.wr(8'hAD, 8'h08);
    col({16'h00C8, 16'h0001, 16'h0002, 16'h0003});
    check(color_result, {16'h00C8, 16'h0001, 16'h0002, 16'h0003});
    check(int_line, 1'b0);
    col({16'h003C, 48'h0});
    check(int_line, 1'b1);
    host.wr(8'hAC, 8'h40);
    col({16'h00C8, 48'h0});
    check({int_line, aux_line}, 2'b10);
  endtask
  task automatic t_near;
    logic p;
    int   k;
    host.wr(8'hAC, 8'h20);
    host.wr(8'hAD, 8'h00);
    nr(8'h28, p);
    check({p, near_result, int_line}, 10'h250);
    nr(8'h14, p);
    check(int_line, 1'b0);
    nr(8'h05, p);
    check(int_line, 1'b1);
    host.wr(8'hAD, 8'h01);
    nr(8'h28, p);
    nr(8'h14, p);
    check({p, near_result}, 9'h11E);
    host.wr(8'hAD, 8'h03);
    repeat (3) nr(8'h08, p);
    nr(8'h10, p);
    check({p, near_result}, 9'h10A);
    for (int d = 0; d < 2; d++)
    begin
      host.wr(8'hAD, 8'h05 | 8'(d << 1));
      k = 0;
      repeat (8)
      begin
        nr(8'h08, p);
        k += p;
      end
      check(k, 4 >> d);
    end
    // Raw samples again, so the next sample publishes at once
    host.wr(8'hAD, 8'h00);
    host.wr(8'hAC, 8'h10);
    nr(8'h28, p);
    check({int_line, aux_line}, 2'b10);
  endtask
  task automatic t_motion;
    logic ex;
    logic last;
    host.wr(8'hAD, 8'h20);
    ambient_integrating = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      host.wr(8'hB0, 8'(c));
      enter;
      check({ambient_abort, motion_capture_state}, 2'b11);
      for (int i = 0; i < (1 << c); i++)
      begin
        ms(32'h0, ex);
        last = (i == (1 << c) - 1);
        check({ex, ambient_restart, ambient_skip_wait}, {3{last}});
      end
    end
    host.wr(8'hB0, 8'h01);
    ambient_integrating = 1'b0;
    enter;
    check(ambient_abort, 1'b0);
    ms(32'h0, ex);
    ms(32'h0000_0040, ex);
    ms(32'h0, ex);
    check(ex, 1'b0);
    ms(32'h0, ex);
    check(ex, 1'b1);
    for (int b = 0; b < 4; b++)
    begin
      host.wr(8'hB0, 8'h20 >> b);
      enter;
      ms(32'h0000_00FF << (8 * ((b + 1) % 4)), ex);
      check(ex, 1'b0);
      ms(32'h0000_00FF << (8 * b), ex);
      check(ex, 1'b1);
    end
  endtask
  // Main sequence
  initial
  begin
    {reset_n, color_valid, near_sample_valid, motion_enter} = 4'h0;
    {motion_sample_valid, ambient_integrating} = 2'b00;
    color_raw = 64'h0;
    near_sample = 8'h00;
    motion_sample = 32'h0;
    ambient_low_thr = 16'h0032;
    ambient_high_thr = 16'h0046;
    near_low_thr = 8'h0A;
    near_high_thr = 8'h1E;
    motion_exit_threshold = 8'h32;
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    t_regs;
    t_color;
    t_near;
    t_motion;
    close_out;
  end
  // Watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    close_out;
  end
endmodule // sensor_int_filter_config_tb
